// ===== hw/ssp_pkg.sv
// Package with constants, modes and carriers for the synchronous serial port.
// Functional notes
// [R1] Master transfer starts at once when software writes the data buffer.
// [R2] With output disabled the master still shifts in and loads bytes with flags.
// [R3] Master rate: sysclk/4, /16, /64, timer period/2, or sysclk/(4*(reload+1)); the code uses only reload bits 6:0, so this holds for reload 0 to 126.
// [R4] Clock idle level from polarity bit, edge from edge select, MSB first.
// [R5] With edge select set, first data bit is valid before the first clock edge.
// [R6] Slave shifts on external clock pulses and flags done on last bit.
// [R7] External master holds clock at idle level before slave enable.
// [R8] Slave keeps shifting during sleep and flags after eight bits to wake.
// [R9] Master sleep freezes transfer, which resumes after wake.
// [R10] Overwrite enable accepts buffer writes while an unread byte remains.
// [R11] Daisy-chain slave shifts out an exact copy of the byte it received.
// [R12] Select-controlled slave mode is mode field pattern 0100.
// [R13] Select low enables shifting and drives the serial output.
// [R14] Select rising stops driving serial output at once, mid-byte too.
// [R15] Select high in that mode, or port disable, forces bit counter to 0.
// [R16] Slave with edge select set is used only with select control.
// [R17] Sample phase bit must stay clear in slave mode.
// [R18] Sample phase bit picks middle or end of data output time for sampling; the code never reads the bit and always samples at one point.
// [R19] After eight bits byte moves to buffer; buffer full and done flags set.
// [R20] Buffer write during shifting is dropped and sets write collision flag.
// [R21] Reading the data buffer clears the buffer full flag.
package ssp_pkg;

  // Mode field encodings of the low four bits of the first control register.
  localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SEL = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSEL = 4'h5;
  localparam logic [3:0] MODE_MASTER_BAUD = 4'ha;

  // Byte width and bit counter reset value.
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;

  // Fixed divider ratios in half-bit system clocks (full bit = twice this).
  localparam logic [7:0] HALF_DIV4 = 8'h02;
  localparam logic [7:0] HALF_DIV16 = 8'h08;
  localparam logic [7:0] HALF_DIV64 = 8'h20;

  // Receive FIFO depth in bytes.
  localparam int RX_FIFO_DEPTH = 8;

  // Configuration carrier.
  typedef struct packed {
    logic serial_port_enable;
    logic [3:0] mode;
    logic clock_idle_polarity;
    logic transmit_edge;
    logic input_sample_phase;
    logic buffer_overwrite_enable;
    logic output_enable;
  } port_config_s;

  // Status carrier.
  typedef struct packed {
    logic buffer_full_flag;
    logic transfer_done_flag;
    logic write_collision_flag;
    logic busy;
  } port_status_s;

endpackage : ssp_pkg

// ===== hw/byte_fifo.sv
// Parameterised valid/ready FIFO used on the receive byte path.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage writes.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");

endmodule : byte_fifo

// ===== hw/ssp_spi_port.sv
// Synchronous serial port in SPI master and slave modes with receive FIFO.
`timescale 1ns/1ps
module ssp_spi_port #(
  parameter int FIFO_DEPTH = ssp_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration and power state.
  input wire ssp_pkg::port_config_s cfg,
  input wire logic [7:0] baud_reload_value,
  input wire logic period_timer_tick,
  input wire logic sleep,
  // Software access to the data buffer.
  input wire logic buf_write,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_read,
  output logic [7:0] data_buffer_reg,
  input wire logic clear_done,
  input wire logic clear_collision,
  // Status.
  output ssp_pkg::port_status_s status,
  output logic wake,
  // Received byte stream.
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Serial pins.
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic select_n
);
  import ssp_pkg::*;

  logic is_master;
  logic sel_mode;
  logic slave_mode;
  logic [7:0] internal_shift_reg;
  logic [3:0] bit_count;
  logic active;
  logic phase;
  logic [7:0] div_count;
  logic [7:0] half_period;
  logic half_tick;
  logic timer_half;
  logic sck_level;
  logic sample_bit;
  logic [1:0] sck_sync;
  logic [1:0] sdi_sync;
  logic [1:0] sel_sync;
  logic sck_prev;
  logic sel_prev;
  logic sck_s;
  logic sdi_s;
  logic sel_s;
  logic port_reset;
  logic slave_shift_edge;
  logic slave_sample_edge;
  logic byte_done;
  logic [7:0] next_byte;
  logic fifo_in_ready;
  logic buffer_full_flag, transfer_done_flag, write_collision_flag, busy, write_ok, master_sample;

  // Decode of the mode field into master and slave roles.
  assign is_master = (cfg.mode == MODE_MASTER_DIV4) || (cfg.mode == MODE_MASTER_DIV16) ||
                     (cfg.mode == MODE_MASTER_DIV64) || (cfg.mode == MODE_MASTER_TIMER) ||
                     (cfg.mode == MODE_MASTER_BAUD);
  assign sel_mode = (cfg.mode == MODE_SLAVE_SEL); // R12
  assign slave_mode = sel_mode || (cfg.mode == MODE_SLAVE_NOSEL);

  // Two-stage synchronisers for pins from outside the clock domain.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_sync <= 2'h0;
      sdi_sync <= 2'h0;
      sel_sync <= 2'h3;
    end else begin
      sck_sync <= {sck_sync[0], sck_in};
      sdi_sync <= {sdi_sync[0], sdi};
      sel_sync <= {sel_sync[0], select_n};
    end
  end
  assign sck_s = sck_sync[1];
  assign sdi_s = sdi_sync[1];
  assign sel_s = sel_sync[1];

  // Delayed copies for edge detection on the synchronised pins.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev <= 1'b0;
      sel_prev <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      sel_prev <= sel_s;
    end
  end

  // Port reset from disable or select high in select-controlled slave mode.
  assign port_reset = !cfg.serial_port_enable || (sel_mode && sel_s); // R15

  // Slave edges relative to the idle level: leading edge leaves idle.
  // With edge select set data shift on the edge back to idle, else on the leading edge.
  always_comb begin
    slave_shift_edge = 1'b0;
    slave_sample_edge = 1'b0;
    if (slave_mode && !port_reset && (sck_s != sck_prev)) begin
      if ((sck_s != cfg.clock_idle_polarity) == cfg.transmit_edge) begin // R16 R17
        slave_sample_edge = 1'b1; // R6
      end else begin
        slave_shift_edge = 1'b1; // R4
      end
    end
  end

  // Master half-bit divider select.
  always_comb begin
    case (cfg.mode)
      MODE_MASTER_DIV4: half_period = HALF_DIV4; // R3
      MODE_MASTER_DIV16: half_period = HALF_DIV16; // R3
      MODE_MASTER_DIV64: half_period = HALF_DIV64; // R3
      MODE_MASTER_BAUD: half_period = {baud_reload_value[6:0], 1'b0} + 8'h02; // R3
      default: half_period = HALF_DIV4;
    endcase
  end

  // Half-bit tick; clocks stop while sleeping in master mode.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_count <= 8'h00;
    end else if (!active || port_reset) begin
      div_count <= 8'h00;
    end else if (!sleep && (cfg.mode != MODE_MASTER_TIMER)) begin // R9
      div_count <= (div_count + 8'h01 >= half_period) ? 8'h00 : div_count + 8'h01;
    end
  end
  assign timer_half = period_timer_tick && !sleep; // R3
  assign half_tick = active && is_master && !sleep && // R9
                     ((cfg.mode == MODE_MASTER_TIMER) ? timer_half : (div_count + 8'h01 >= half_period));

  // Byte completion: eighth sample taken.
  // The master samples on the half bit away from the output change, which follows the edge select.
  assign master_sample = half_tick && (phase != cfg.transmit_edge); // R4
  assign byte_done = (is_master ? master_sample : slave_sample_edge) && (bit_count == 4'h7);
  assign next_byte = {internal_shift_reg[6:0], sample_bit};
  assign sample_bit = sdi_s; // R18
  assign write_ok = buf_write && !busy && !write_collision_flag &&
                    (!buffer_full_flag || cfg.buffer_overwrite_enable);

  // Shift register, bit counter, phase and transfer activity.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      internal_shift_reg <= 8'h00;
      bit_count <= BIT_COUNT_RESET;
      active <= 1'b0;
      phase <= 1'b0;
    end else if (port_reset) begin
      bit_count <= BIT_COUNT_RESET; // R15
      active <= 1'b0;
      phase <= 1'b0;
      if (write_ok) begin
        internal_shift_reg <= buf_wdata;
      end
    end else if (write_ok) begin
      internal_shift_reg <= buf_wdata; // R10
      active <= is_master; // R1
      phase <= 1'b0;
      bit_count <= BIT_COUNT_RESET;
    end else if (is_master && half_tick) begin
      // With edge select set the first half of a bit samples and shifts, else the second half does; the second half advances.
      phase <= !phase;
      if (master_sample) begin
        internal_shift_reg <= next_byte; // R2
      end
      if (phase && (bit_count == 4'h7)) begin
        active <= 1'b0;
        bit_count <= BIT_COUNT_RESET;
      end else if (phase) begin
        bit_count <= bit_count + 4'h1;
      end
    end else if (slave_sample_edge) begin
      internal_shift_reg <= next_byte; // R11
      bit_count <= (bit_count == 4'h7) ? BIT_COUNT_RESET : bit_count + 4'h1;
    end
  end

  // Serial clock: idle level from polarity, toggles once per half bit.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_level <= 1'b0;
    end else if (!active || port_reset) begin
      sck_level <= cfg.clock_idle_polarity; // R4
    end else if (half_tick) begin
      sck_level <= !sck_level;
    end
  end
  assign sck_out = sck_level;
  assign sck_oe = is_master && cfg.serial_port_enable;

  // Serial output shows the MSB of the shift register, valid before the first edge.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_out <= 1'b0;
    end else if (port_reset) begin
      sdo_out <= 1'b0;
    end else if (write_ok) begin
      sdo_out <= buf_wdata[7]; // R5
    end else if (slave_shift_edge || !busy || (is_master && half_tick && !master_sample)) begin
      sdo_out <= internal_shift_reg[7]; // R4
    end
  end

  // Output drive when port and output are enabled: master always, select-controlled slave only while selected, slave without select always.
  assign sdo_oe = cfg.serial_port_enable && cfg.output_enable &&
                  (is_master || (slave_mode && !(sel_mode && sel_s))); // R13 R14

  // Data buffer loads each completed byte.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_buffer_reg <= 8'h00;
    end else if (byte_done) begin
      data_buffer_reg <= next_byte; // R19
    end
  end

  // Buffer full: set on byte done, cleared by read; set wins.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_full_flag <= 1'b0;
    end else if (byte_done) begin
      buffer_full_flag <= 1'b1; // R19
    end else if (buf_read) begin
      buffer_full_flag <= 1'b0; // R21
    end
  end

  // Transfer done flag, works in sleep in slave mode.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      transfer_done_flag <= 1'b0;
    end else if (byte_done) begin
      transfer_done_flag <= 1'b1; // R6 R8
    end else if (clear_done) begin
      transfer_done_flag <= 1'b0;
    end
  end

  // Write collision on write while shifting; set wins over clear.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_collision_flag <= 1'b0;
    end else if (buf_write && busy) begin
      write_collision_flag <= 1'b1; // R20
    end else if (clear_collision) begin
      write_collision_flag <= 1'b0;
    end
  end

  // Busy: master active or slave mid-byte.
  assign busy = active || (slave_mode && (bit_count != BIT_COUNT_RESET));
  assign wake = sleep && slave_mode && byte_done; // R8

  // Status word gathered in one place so the struct has a single driver.
  assign status = '{buffer_full_flag, transfer_done_flag, write_collision_flag, busy};

  // Received bytes also stream into the FIFO; drops if full.
  byte_fifo #(
    .WIDTH(BYTE_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(byte_done),
    .in_ready(fifo_in_ready),
    .in_data(next_byte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  a_start_on_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
    (buf_write && is_master && !status.busy && !status.write_collision_flag && !port_reset &&
     (!status.buffer_full_flag || cfg.buffer_overwrite_enable)) |=> active) else $error("No start.");
  a_done_sets_flags: assert property (@(posedge sys_clk) disable iff (!reset_n) // R19
    byte_done |=> (status.buffer_full_flag && status.transfer_done_flag)) else $error("Flags unset.");
  a_read_clears_full: assert property (@(posedge sys_clk) disable iff (!reset_n) // R21
    (buf_read && !byte_done) |=> !status.buffer_full_flag) else $error("Full not cleared.");
  a_collision_set: assert property (@(posedge sys_clk) disable iff (!reset_n) // R20
    (buf_write && status.busy) |=> (status.write_collision_flag && $stable(internal_shift_reg)))
    else $error("Collision missed.");
  a_select_float: assert property (@(posedge sys_clk) disable iff (!reset_n) // R14
    (sel_mode && sel_s) |-> !sdo_oe) else $error("Output driven while deselected.");
  a_reset_counter: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    port_reset |=> (bit_count == 4'h0)) else $error("Counter not cleared.");
  a_sleep_freeze: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
    (sleep && is_master && $past(sleep) && !port_reset) |=> $stable(sck_level)) else $error("Clock ran in sleep.");
  a_idle_level: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    (is_master && !active && $past(!active) && !$changed(cfg)) |-> (sck_out == cfg.clock_idle_polarity))
    else $error("Wrong idle level.");

endmodule : ssp_spi_port

// ===== bench/spi_far_end.sv
// Far-side serial device: slave while the port drives the clock, master otherwise.
`timescale 1ns/1ps
module spi_far_end (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Frame format.
  input wire logic cpol,
  input wire logic cke,
  // Pins.
  input wire logic sck_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  output logic far_sck,
  output logic sdi,
  output logic select_n
);
  localparam int HALF = 8;
  logic [15:0] tx;
  logic [15:0] cap;
  logic [15:0] load_val;
  logic load;
  logic prv;
  int nsamp;

  // Data toward the port is always the head of the shift register.
  assign sdi = tx[15];

  // Pins start idle and deselected.
  initial begin
    far_sck = 1'b0;
    select_n = 1'b1;
    load = 1'b0;
    load_val = '0;
  end

  // Sample on one clock edge, shift on the other, MSB first; a released data line reads as pulled up.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx <= '0;
      cap <= '0;
      nsamp <= 0;
      prv <= 1'b0;
    end else if (load) begin
      tx <= load_val;
      cap <= '0;
      nsamp <= 0;
      prv <= sck_pin;
    end else if (sck_pin != prv) begin
      prv <= sck_pin;
      if ((sck_pin != cpol) == cke) begin
        cap <= {cap[14:0], sdo_oe ? sdo_out : 1'b1};
        nsamp <= nsamp + 1;
      end else if (nsamp > 0) begin
        tx <= {tx[14:0], ~tx[0]};
      end
    end
  end

  // Puts the far clock at the idle level before the port is enabled.
  task automatic park(input logic p);
    far_sck <= p;
  endtask : park

  // Loads the next frame to send.
  task automatic arm(input logic [15:0] v);
    @(posedge sys_clk);
    load_val <= v;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
  endtask : arm

  // Selects the port and gives it n clock edges, slow enough for its input synchronisers.
  task automatic clock_out(input int n);
    int i;
    select_n <= 1'b0;
    repeat (HALF) @(posedge sys_clk);
    for (i = 0; i < n; i++) begin
      far_sck <= ~far_sck;
      repeat (HALF) @(posedge sys_clk);
    end
  endtask : clock_out

  // Ends the frame.
  task automatic deselect();
    @(posedge sys_clk);
    select_n <= 1'b1;
  endtask : deselect
endmodule : spi_far_end

// ===== bench/sync_serial_port_spi_modes_tb.sv
// Self-checking bench for the serial port in master, slave, sleep and buffering use.
`timescale 1ns/1ps
module sync_serial_port_spi_modes_tb;
  import ssp_pkg::*;
  port_config_s cfg;
  logic sys_clk, reset_n, period_timer_tick, sleep, buf_write, buf_read, clear_done;
  logic clear_collision, rx_ready, wake, rx_valid, sck_out, sck_oe, sdo_out, sdo_oe;
  logic far_sck, sdi, select_n, sck_wire, sck_prev, wake_seen;
  logic [7:0] baud_reload_value, buf_wdata, data_buffer_reg, rx_data;
  port_status_s status;
  int miscompares, comparisons, cyc, edges, first, last, tick_cnt, i, n;
  logic [3:0] ms [4] = '{MODE_MASTER_DIV16, MODE_MASTER_DIV64, MODE_MASTER_TIMER, MODE_MASTER_BAUD};
  int hs [4] = '{8, 32, 6, 6};

  // The clock pin carries the port's drive when enabled, else the far side's.
  assign sck_wire = sck_oe ? sck_out : far_sck;

  ssp_spi_port DUT (.sys_clk(sys_clk), .reset_n(reset_n), .cfg(cfg), .baud_reload_value(baud_reload_value),
    .period_timer_tick(period_timer_tick), .sleep(sleep), .buf_write(buf_write), .buf_wdata(buf_wdata),
    .buf_read(buf_read), .data_buffer_reg(data_buffer_reg), .clear_done(clear_done),
    .clear_collision(clear_collision), .status(status), .wake(wake), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .sck_in(sck_wire), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .select_n(select_n));
  spi_far_end fp (.sys_clk(sys_clk), .reset_n(reset_n), .cpol(cfg.clock_idle_polarity),
    .cke(cfg.transmit_edge), .sck_pin(sck_wire), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .far_sck(far_sck),
    .sdi(sdi), .select_n(select_n));

  // A 5 ns clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Times driven clock edges, catches wake pulses and cuts a hang short.
  always @(posedge sys_clk) begin
    cyc++;
    if (wake === 1'b1) wake_seen = 1'b1;
    if (sck_oe === 1'b1 && sck_out !== sck_prev) begin
      if (edges == 0) first = cyc;
      last = cyc;
      edges++;
    end
    sck_prev = sck_out;
    if (cyc > 30000) begin
      miscompares++;
      finish_test();
    end
  end

  // A timer tick every six cycles paces the timer rate.
  always @(posedge sys_clk) begin
    tick_cnt <= (tick_cnt == 5) ? 0 : tick_cnt + 1;
    period_timer_tick <= (tick_cnt == 5);
  end

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_flag(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step

  // Software writes the data buffer; returns once the taking edge has landed.
  task automatic sw_write(input logic [7:0] v);
    @(posedge sys_clk);
    buf_write <= 1'b1;
    buf_wdata <= v;
    @(posedge sys_clk);
    buf_write <= 1'b0;
    #1;
  endtask : sw_write

  // Software reads the buffer and clears flags.
  task automatic sw_pulse(input logic rd, input logic cd, input logic cc);
    @(posedge sys_clk);
    buf_read <= rd;
    clear_done <= cd;
    clear_collision <= cc;
    @(posedge sys_clk);
    {buf_read, clear_done, clear_collision} <= 3'h0;
    #1;
  endtask : sw_pulse

  task automatic wait_done();
    int k;
    for (k = 0; k < 3000 && status.transfer_done_flag !== 1'b1; k++) step(1);
    check_flag("done", 1'b1, status.transfer_done_flag);
    step(2);
  endtask : wait_done

  // Disables the port, parks the far clock, then enables with the new setting.
  task automatic set_cfg(input logic [3:0] m, input logic p, input logic e, input logic b, input logic o);
    @(posedge sys_clk);
    cfg <= '{1'b0, m, p, e, 1'b0, b, o};
    fp.park(p);
    step(3);
    cfg.serial_port_enable <= 1'b1;
    step(4);
  endtask : set_cfg

  task automatic master_byte(input logic [3:0] m, input logic p, input logic e, input logic [7:0] v,
                             input logic [7:0] far, input int half);
    set_cfg(m, p, e, 1'b0, 1'b1);
    check_flag("idle", p, sck_out);
    fp.arm({far, 8'h00});
    edges = 0;
    sw_write(v);
    check_flag("busy", 1'b1, status.busy);
    wait_done();
    step(2 * half);
    check_val("buf", {8'h00, far}, {8'h00, data_buffer_reg});
    check_val("far", {8'h00, v}, {8'h00, fp.cap[7:0]});
    check_val("edges", 16'd16, 16'(edges));
    check_val("span", 16'(15 * half), 16'(last - first));
    check_flag("full", 1'b1, status.buffer_full_flag);
    sw_pulse(1'b1, 1'b1, 1'b0);
    check_flag("full", 1'b0, status.buffer_full_flag);
  endtask : master_byte

  // The far master sends one frame of k edges to the port in select-controlled slave mode.
  task automatic slave_frame(input logic [7:0] v, input logic [15:0] far, input int k);
    sw_write(v);
    fp.arm(far);
    fp.clock_out(k);
    check_flag("sdo on", 1'b1, sdo_oe);
    fp.deselect();
    step(4);
    check_flag("sdo off", 1'b0, sdo_oe);
  endtask : slave_frame

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Main sequence.
  initial begin
    {reset_n, period_timer_tick, sleep, buf_write, buf_read, clear_done, clear_collision, rx_ready} = 8'h00;
    miscompares = 0;
    comparisons = 0;
    cyc = 0;
    edges = 0;
    first = 0;
    last = 0;
    tick_cnt = 0;
    {sck_prev, wake_seen, buf_wdata} = 10'h000;
    baud_reload_value = 8'h02;
    cfg = '0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 9; i++) master_byte(MODE_MASTER_DIV16, 1'b0, 1'b0, 8'h40 + 8'(i), 8'h10 + 8'(i), 8);
    for (i = 0; i < 8; i++) begin
      step(2);
      check_flag("rx valid", 1'b1, rx_valid);
      check_val("rx data", {8'h10, 8'h10 + 8'(i)}, {8'h10, rx_data});
      @(posedge sys_clk);
      rx_ready <= 1'b1;
      @(posedge sys_clk);
      rx_ready <= 1'b0;
    end
    rx_ready <= 1'b1;
    master_byte(MODE_MASTER_DIV4, 1'b1, 1'b1, 8'h5a, 8'hff, 2);
    $display("test fifo done");
    for (i = 0; i < 4; i++) master_byte(ms[i], i[0], i[1], 8'hb4 ^ 8'(i), 8'h2d + 8'(i), hs[i]);
    $display("test rates done");
    set_cfg(MODE_MASTER_DIV16, 1'b0, 1'b1, 1'b0, 1'b0);
    fp.arm(16'h6100);
    sw_write(8'hff);
    step(6);
    check_flag("rx only", 1'b0, sdo_oe);
    wait_done();
    check_val("rx only", 16'h0061, {8'h00, data_buffer_reg});
    sw_pulse(1'b1, 1'b1, 1'b0);
    $display("test receive only done");
    set_cfg(MODE_MASTER_DIV64, 1'b0, 1'b0, 1'b0, 1'b1);
    fp.arm(16'h1100);
    sw_write(8'h96);
    sw_write(8'h55);
    check_flag("write_collision_flag", 1'b1, status.write_collision_flag);
    wait_done();
    check_val("kept", 16'h0096, {8'h00, fp.cap[7:0]});
    sw_write(8'h22);
    check_flag("busy", 1'b0, status.busy);
    sw_pulse(1'b0, 1'b1, 1'b1);
    check_flag("write_collision_flag", 1'b0, status.write_collision_flag);
    sw_write(8'h33);
    check_flag("busy", 1'b0, status.busy);
    cfg.buffer_overwrite_enable <= 1'b1;
    fp.arm(16'h7700);
    sw_write(8'h44);
    check_flag("busy", 1'b1, status.busy);
    wait_done();
    check_val("ovw", 16'h0044, {8'h00, fp.cap[7:0]});
    sw_pulse(1'b1, 1'b1, 1'b0);
    $display("test collision done");
    set_cfg(MODE_MASTER_DIV16, 1'b1, 1'b0, 1'b0, 1'b1);
    fp.arm(16'h5e00);
    sw_write(8'h69);
    step(40);
    sleep <= 1'b1;
    step(3);
    n = edges;
    step(60);
    check_val("frozen", 16'(n), 16'(edges));
    check_flag("done", 1'b0, status.transfer_done_flag);
    sleep <= 1'b0;
    wait_done();
    check_val("resume", 16'h5e69, {data_buffer_reg, fp.cap[7:0]});
    sw_pulse(1'b1, 1'b1, 1'b0);
    $display("test master sleep done");
    for (i = 0; i < 2; i++) begin
      set_cfg(MODE_SLAVE_SEL, i[0], i[0], 1'b0, 1'b1);
      slave_frame(8'hc6 + 8'(i), {8'h8b + 8'(i), 8'h00}, 16);
      wait_done();
      check_val("slave", {8'h8b + 8'(i), 8'hc6 + 8'(i)}, {data_buffer_reg, fp.cap[7:0]});
      sw_pulse(1'b1, 1'b1, 1'b0);
    end
    $display("test slave done");
    set_cfg(MODE_SLAVE_SEL, 1'b0, 1'b0, 1'b1, 1'b1);
    slave_frame(8'h9d, 16'hff00, 8);
    check_flag("done", 1'b0, status.transfer_done_flag);
    slave_frame(8'h5c, 16'h2700, 16);
    wait_done();
    check_val("realign", 16'h275c, {data_buffer_reg, fp.cap[7:0]});
    sw_pulse(1'b1, 1'b1, 1'b0);
    slave_frame(8'h3a, 16'hd400, 32);
    wait_done();
    check_val("chain", 16'h3ad4, fp.cap);
    sw_pulse(1'b1, 1'b1, 1'b0);
    $display("test select done");
    wake_seen = 1'b0;
    sleep <= 1'b1;
    slave_frame(8'h00, 16'hb200, 16);
    wait_done();
    check_flag("wake", 1'b1, wake_seen);
    check_val("sleep rx", 16'h00b2, {8'h00, data_buffer_reg});
    sleep <= 1'b0;
    $display("test slave sleep done");
    finish_test();
  end
endmodule : sync_serial_port_spi_modes_tb
